// File: hdl/mdsr_pkg.sv
// Package for the motor driver status register bank.
// Assumes a single 100 MHz clock and byte-wide register reads from the serial front end.
package mdsr_pkg;

  // Status register offsets
  localparam logic [7:0] OFS_FAULT_STATUS   = 8'h00;
  localparam logic [7:0] OFS_SPEED_ESTIMATE = 8'h01;
  localparam logic [7:0] OFS_RIPPLE_LOW     = 8'h02;
  localparam logic [7:0] OFS_RIPPLE_HIGH    = 8'h03;
  localparam logic [7:0] OFS_MOTOR_VOLTAGE  = 8'h04;
  localparam logic [7:0] OFS_MOTOR_CURRENT  = 8'h05;
  localparam logic [7:0] OFS_INTERNAL_DUTY  = 8'h06;

  // Configuration offsets that hold output-dependent fields
  localparam logic [7:0] OFS_CONFIG0        = 8'h09;
  localparam logic [7:0] OFS_CONFIG3        = 8'h0c;
  localparam logic [7:0] OFS_CONFIG4        = 8'h0d;
  localparam logic [7:0] OFS_REG_CTRL0      = 8'h0e;

  // Bits of those registers that are frozen while the outputs are enabled
  localparam logic [7:0] LOCK_CONFIG0       = 8'h19;
  localparam logic [7:0] LOCK_CONFIG3       = 8'hff;
  localparam logic [7:0] LOCK_CONFIG4       = 8'h0c;
  localparam logic [7:0] LOCK_REG_CTRL0     = 8'h1c;

  // Fault status field positions
  localparam int BIT_FAULT_SUMMARY = 7;
  localparam int BIT_STALL         = 5;
  localparam int BIT_OVERCURRENT   = 4;
  localparam int BIT_OVERVOLTAGE   = 3;
  localparam int BIT_THERMAL       = 2;
  localparam int BIT_POWER_ON      = 1;
  localparam int BIT_COUNT_DONE    = 0;

  // Reset values
  localparam logic [7:0] RST_STATUS   = 8'h00;
  localparam logic [7:0] RST_UNMAPPED = 8'h00;

  // Ripple counter width
  localparam int RIPPLE_W = 16;

  // Motor voltage scaling: code B0h stands for 11 V, saturating at FFh
  localparam logic [21:0] VM_FS_MV   = 22'h002af8;
  localparam logic [21:0] VM_FS_CODE = 22'h0000b0;
  localparam logic [7:0]  CODE_MAX   = 8'hff;

  // Motor current scaling: raw 100h is full scale, reported as C0h
  localparam logic [16:0] IM_FS_CODE = 17'h000c0;
  localparam int          IM_RAW_W   = 9;
  localparam int          IM_SHIFT   = 8;

  // Fault conditions from the protection engines
  typedef struct packed {
    logic stall;
    logic overcurrent;
    logic overvoltage;
    logic thermal;
  } mdsr_events_s;

  // Configuration write passed on to the configuration bank
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
  } mdsr_cfg_wr_s;

  // Complete state of the top module
  typedef struct packed {
    logic [7:0]   fault;
    logic         pin_n;
    logic [7:0]   rdata;
    logic         rvalid;
    logic [7:0]   volt;
    logic [7:0]   curr;
    mdsr_cfg_wr_s cfg;
    logic         cnt_clear_ret;
    logic         flt_clear_ret;
  } mdsr_state_s;

  // Complete state of the ripple counter
  typedef struct packed {
    logic [RIPPLE_W-1:0] count;
    logic                done;
  } mdsr_ripple_s;

endpackage

// File: hdl/mdsr_ripple_cnt.sv
// Ripple counter with threshold latch for the status register bank.
// Assumes ripple pulses and clear commands are one-cycle signals on the same clock.
`timescale 1ns/1ns
module mdsr_ripple_cnt #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ripple_pulse,
  input  wire logic             clear,
  input  wire logic [CNT_W-1:0] threshold,
  output logic      [CNT_W-1:0] count,
  output logic                  done
);

  // The status bank reads the count as two bytes
  if (CNT_W != mdsr_pkg::RIPPLE_W) begin : g_bad_width
    $error("Ripple counter width must match the two status bytes");
  end

  mdsr_pkg::mdsr_ripple_s q_ff;   // Registered state
  mdsr_pkg::mdsr_ripple_s nxt_q;  // Next state

  // Next state: clear first, then count, then compare
  always_comb begin
    nxt_q = q_ff;
    if (clear) begin
      nxt_q.count = '0;
    end
    // A ripple in the clear cycle is still counted, so none is lost
    if (ripple_pulse && (nxt_q.count != {CNT_W{1'b1}})) begin
      nxt_q.count = nxt_q.count + CNT_W'(1);
    end
    // Clear goes first: in the clear cycle the flag sets only if the restarted count exceeds the threshold
    nxt_q.done = (q_ff.done && !clear) || (nxt_q.count > threshold);
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign count = q_ff.count;
  assign done  = q_ff.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_done_latch: assert property ((count > threshold) && !clear |=> done)
    else $error("Count-done flag not latched above threshold");
  a_clear_count: assert property (clear && !ripple_pulse |=> count == '0 && !done)
    else $error("Clear did not zero the ripple count");

endmodule

// File: hdl/mdsr_status_regs.sv
// Status register bank of a brushed-motor H-bridge driver.
// Assumes the serial front end, the configuration bank and the protection,
// regulation and ripple engines all run on CLK; their signals need no synchroniser.
//
// Notes on behaviour
// - Summary fault bit 7 set while faults
// - Fault pin low whenever summary bit set
// - Stall flag bit 5 reports motor stall
// - Overcurrent flag bit 4 set on event
// - Overvoltage flag bit 3 set on event
// - Thermal flag bit 2 set on event
// - Power-on flag low until fault clear
// - Power-on flag latches high on fault clear
// - Count-done latches when count exceeds threshold
// - Clear-counter command clears count-done flag
// - Speed estimate read as eight bits
// - Ripple count low byte at offset 2
// - Ripple count high byte at offset 3
// - Voltage code linear, B0h means 11 V
// - Voltage code saturates at FFh
// - Output-dependent fields locked while outputs enabled
// - Fault status reads 00h after reset
// - Current code C0h means full scale
// - Counter clear zeroes count, self-clears bit
`timescale 1ns/1ns
module mdsr_status_regs #(
  parameter int RIPPLE_W = 16,
  parameter int VM_MV_W  = 14
) (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  // Fault conditions and supply status
  input  wire mdsr_pkg::mdsr_events_s        FAULT_EVENTS,
  input  wire logic                          VCC_OK,
  // Command bits held in the configuration bank
  input  wire logic                          CLR_FAULT_CMD,
  input  wire logic                          CLR_COUNTER_CMD,
  input  wire logic                          EN_OUT,
  // Engine values
  input  wire logic                          RIPPLE_PULSE,
  input  wire logic [RIPPLE_W-1:0]           RIPPLE_THRESHOLD,
  input  wire logic [7:0]                    SPEED_IN,
  input  wire logic [VM_MV_W-1:0]            MOTOR_MV,
  input  wire logic [mdsr_pkg::IM_RAW_W-1:0] MOTOR_I_RAW,
  input  wire logic [5:0]                    DUTY_IN,
  // Register read port
  input  wire logic                          RD_EN,
  input  wire logic [7:0]                    RD_ADDR,
  output logic      [7:0]                    RD_DATA,
  output logic                               RD_VALID,
  // Configuration write gate
  input  wire logic                          CFG_WR_EN,
  input  wire logic [7:0]                    CFG_WR_ADDR,
  input  wire logic [7:0]                    CFG_WR_DATA,
  output mdsr_pkg::mdsr_cfg_wr_s             CFG_WR_OUT,
  // Self-clearing returns for the command bits
  output logic                               CLR_FAULT_RET,
  output logic                               CLR_COUNTER_RET,
  // Fault pin, active low
  output logic                               FAULT_PIN_N
);

  // Widths the scaling arithmetic can serve
  if (RIPPLE_W != mdsr_pkg::RIPPLE_W) begin : g_bad_ripple
    $error("Ripple width must be sixteen bits");
  end
  // Above fourteen bits the millivolt product overflows the 22-bit scaler
  if ((VM_MV_W < 4) || (VM_MV_W > 14)) begin : g_bad_mv
    $error("Motor millivolt width out of range");
  end

  mdsr_pkg::mdsr_state_s q_ff;          // Registered state
  mdsr_pkg::mdsr_state_s nxt_q;         // Next state
  logic [RIPPLE_W-1:0]   ripple_count;  // Counter value
  logic                  count_done;    // Latched threshold flag
  logic                  cnt_clear_act; // Clear-counter acts this cycle
  logic                  flt_clear_act; // Clear-fault acts this cycle
  logic [21:0]           vm_prod;       // Millivolts times full-scale code
  logic [21:0]           vm_code;       // Scaled voltage before saturation
  logic [16:0]           im_code;       // Scaled current before saturation
  logic [7:0]            lock_mask;     // Bits frozen for the write address

  // Command bits act once per assertion; the return pulse drops them
  assign cnt_clear_act = CLR_COUNTER_CMD && !q_ff.cnt_clear_ret;
  assign flt_clear_act = CLR_FAULT_CMD && !q_ff.flt_clear_ret;

  // Ripple counter and its threshold latch
  mdsr_ripple_cnt #(
    .CNT_W        (RIPPLE_W)
  ) u_ripple (
    .clk          (CLK),
    .nrst         (NRST),
    .ripple_pulse (RIPPLE_PULSE),
    .clear        (cnt_clear_act),
    .threshold    (RIPPLE_THRESHOLD),
    .count        (ripple_count),
    .done         (count_done)
  );

  // Linear scaling of the analogue readings
  always_comb begin
    vm_prod = 22'(MOTOR_MV) * mdsr_pkg::VM_FS_CODE;
    vm_code = vm_prod / mdsr_pkg::VM_FS_MV;
    // Full scale raw 100h maps to C0h; raw values from 156h up saturate below
    im_code = (17'(MOTOR_I_RAW) * mdsr_pkg::IM_FS_CODE) >> mdsr_pkg::IM_SHIFT;
  end

  // Locked bits per configuration address
  always_comb begin
    if (CFG_WR_ADDR == mdsr_pkg::OFS_CONFIG0) begin
      lock_mask = mdsr_pkg::LOCK_CONFIG0;
    end else if (CFG_WR_ADDR == mdsr_pkg::OFS_CONFIG3) begin
      lock_mask = mdsr_pkg::LOCK_CONFIG3;
    end else if (CFG_WR_ADDR == mdsr_pkg::OFS_CONFIG4) begin
      lock_mask = mdsr_pkg::LOCK_CONFIG4;
    end else if (CFG_WR_ADDR == mdsr_pkg::OFS_REG_CTRL0) begin
      lock_mask = mdsr_pkg::LOCK_REG_CTRL0;
    end else begin
      lock_mask = 8'h00;
    end
  end

  // Next-state logic for every register of the bank
  always_comb begin
    nxt_q = q_ff;

    // Stall and protection flags: set wins over the clear-fault command
    if (flt_clear_act) begin
      nxt_q.fault[mdsr_pkg::BIT_STALL]       = 1'b0;
      nxt_q.fault[mdsr_pkg::BIT_OVERCURRENT] = 1'b0;
      nxt_q.fault[mdsr_pkg::BIT_OVERVOLTAGE] = 1'b0;
      nxt_q.fault[mdsr_pkg::BIT_THERMAL]     = 1'b0;
    end
    if (FAULT_EVENTS.stall) begin
      nxt_q.fault[mdsr_pkg::BIT_STALL] = 1'b1;
    end
    if (FAULT_EVENTS.overcurrent) begin
      nxt_q.fault[mdsr_pkg::BIT_OVERCURRENT] = 1'b1;
    end
    if (FAULT_EVENTS.overvoltage) begin
      nxt_q.fault[mdsr_pkg::BIT_OVERVOLTAGE] = 1'b1;
    end
    if (FAULT_EVENTS.thermal) begin
      nxt_q.fault[mdsr_pkg::BIT_THERMAL] = 1'b1;
    end

    // Power-on flag: forced low while the supply is low, set by clear-fault
    if (!VCC_OK) begin
      nxt_q.fault[mdsr_pkg::BIT_POWER_ON] = 1'b0;
    end else if (flt_clear_act) begin
      nxt_q.fault[mdsr_pkg::BIT_POWER_ON] = 1'b1;
    end

    // Count-done mirrors the latch inside the ripple counter
    nxt_q.fault[mdsr_pkg::BIT_COUNT_DONE] = count_done;

    // Bit 6 is reserved and reads zero
    nxt_q.fault[6] = 1'b0;

    // Summary bit covers the stall and protection flags only
    nxt_q.fault[mdsr_pkg::BIT_FAULT_SUMMARY] = nxt_q.fault[mdsr_pkg::BIT_STALL]
                                             | nxt_q.fault[mdsr_pkg::BIT_OVERCURRENT]
                                             | nxt_q.fault[mdsr_pkg::BIT_OVERVOLTAGE]
                                             | nxt_q.fault[mdsr_pkg::BIT_THERMAL];

    // Pin follows the summary bit in the same cycle, so they never disagree
    nxt_q.pin_n = !nxt_q.fault[mdsr_pkg::BIT_FAULT_SUMMARY];

    // Voltage reading saturates instead of wrapping
    if (vm_code > 22'(mdsr_pkg::CODE_MAX)) begin
      nxt_q.volt = mdsr_pkg::CODE_MAX;
    end else begin
      nxt_q.volt = vm_code[7:0];
    end

    // Current reading saturates the same way
    if (im_code > 17'(mdsr_pkg::CODE_MAX)) begin
      nxt_q.curr = mdsr_pkg::CODE_MAX;
    end else begin
      nxt_q.curr = im_code[7:0];
    end

    // Read port: pure multiplexer, no flag is touched by a read
    nxt_q.rvalid = RD_EN;
    if (!RD_EN) begin
      nxt_q.rdata = q_ff.rdata;
    end else if (RD_ADDR == mdsr_pkg::OFS_FAULT_STATUS) begin
      nxt_q.rdata = q_ff.fault;
    end else if (RD_ADDR == mdsr_pkg::OFS_SPEED_ESTIMATE) begin
      nxt_q.rdata = SPEED_IN;
    end else if (RD_ADDR == mdsr_pkg::OFS_RIPPLE_LOW) begin
      nxt_q.rdata = ripple_count[7:0];
    end else if (RD_ADDR == mdsr_pkg::OFS_RIPPLE_HIGH) begin
      nxt_q.rdata = ripple_count[15:8];
    end else if (RD_ADDR == mdsr_pkg::OFS_MOTOR_VOLTAGE) begin
      nxt_q.rdata = q_ff.volt;
    end else if (RD_ADDR == mdsr_pkg::OFS_MOTOR_CURRENT) begin
      nxt_q.rdata = q_ff.curr;
    end else if (RD_ADDR == mdsr_pkg::OFS_INTERNAL_DUTY) begin
      nxt_q.rdata = {2'b00, DUTY_IN};
    end else begin
      // Reserved offsets answer zero; the host must not rely on them
      nxt_q.rdata = mdsr_pkg::RST_UNMAPPED;
    end

    // Configuration write gate: locked bits are masked while driving
    nxt_q.cfg.we   = CFG_WR_EN;
    nxt_q.cfg.addr = CFG_WR_ADDR;
    nxt_q.cfg.data = CFG_WR_DATA;
    if (EN_OUT) begin
      nxt_q.cfg.mask = ~lock_mask;
    end else begin
      nxt_q.cfg.mask = 8'hff;
    end

    // Return pulse rises one cycle after a command bit acts
    nxt_q.cnt_clear_ret = cnt_clear_act;
    nxt_q.flt_clear_ret = flt_clear_act;
  end

  // State register: everything clears on reset, pin released
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q_ff       <= '0;
      q_ff.fault <= mdsr_pkg::RST_STATUS;
      q_ff.pin_n <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register
  assign RD_DATA         = q_ff.rdata;
  assign RD_VALID        = q_ff.rvalid;
  assign CFG_WR_OUT      = q_ff.cfg;
  assign CLR_FAULT_RET   = q_ff.flt_clear_ret;
  assign CLR_COUNTER_RET = q_ff.cnt_clear_ret;
  assign FAULT_PIN_N     = q_ff.pin_n;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Summary bit is exactly the OR of the four fault flags
  a_summary_or: assert property (q_ff.fault[7] == (|q_ff.fault[5:2]))
    else $error("Summary fault bit disagrees with fault flags");
  // Pin is the inverse of the summary bit at all times
  a_pin_follows: assert property (FAULT_PIN_N == !q_ff.fault[7])
    else $error("Fault pin disagrees with summary bit");
  a_stall_set: assert property (FAULT_EVENTS.stall |=> q_ff.fault[5] && !FAULT_PIN_N)
    else $error("Stall event not flagged");
  a_overcur_set: assert property (FAULT_EVENTS.overcurrent |=> q_ff.fault[4])
    else $error("Overcurrent event not flagged");
  a_overvolt_set: assert property (FAULT_EVENTS.overvoltage |=> q_ff.fault[3])
    else $error("Overvoltage event not flagged");
  a_thermal_set: assert property (FAULT_EVENTS.thermal |=> q_ff.fault[2])
    else $error("Thermal event not flagged");
  a_por_low: assert property (!VCC_OK |=> !q_ff.fault[1])
    else $error("Power-on flag high during undervoltage");
  a_por_hold: assert property (!q_ff.fault[1] && !CLR_FAULT_CMD |=> !q_ff.fault[1])
    else $error("Power-on flag rose without a clear");
  a_por_latch: assert property (flt_clear_act && VCC_OK |=> q_ff.fault[1])
    else $error("Power-on flag not set by clear-fault");
  a_done_cleared: assert property (cnt_clear_act && !RIPPLE_PULSE |-> ##2 !q_ff.fault[0])
    else $error("Count-done survived clear-counter");
  a_cmd_return: assert property (CLR_COUNTER_CMD && !CLR_COUNTER_RET |=> CLR_COUNTER_RET)
    else $error("Clear-counter bit not returned");
  a_volt_sat: assert property (vm_code > 22'h0000ff |=> q_ff.volt == 8'hff)
    else $error("Voltage code wrapped");
  a_lock_mask: assert property (CFG_WR_EN && EN_OUT && CFG_WR_ADDR == 8'h0c
                                |=> CFG_WR_OUT.we && CFG_WR_OUT.mask == 8'h00)
    else $error("Locked field accepted a write while driving");
  a_read_fault: assert property (RD_EN && RD_ADDR == 8'h00
                                 |=> RD_VALID && RD_DATA == $past(q_ff.fault))
    else $error("Fault read returned wrong value");
  a_read_keeps: assert property (RD_EN && q_ff.fault[4] && !flt_clear_act |=> q_ff.fault[4])
    else $error("Read cleared a latched flag");

  c_fault_clear: cover property (q_ff.fault[7] ##[1:20] !q_ff.fault[7]);
  c_count_done:  cover property (!q_ff.fault[0] ##1 q_ff.fault[0]);
  c_por_latch:   cover property (flt_clear_act && VCC_OK);
  c_volt_sat:    cover property (q_ff.volt == 8'hff);

endmodule

// File: verif/mdsr_host_model.sv
// Host-side model of the command bits that the configuration bank holds.
// Assumes the bench asks for a command with a one-cycle request pulse on clk.
`timescale 1ns/1ns
module mdsr_host_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic flt_req,
  input  wire logic cnt_req,
  input  wire logic flt_ret,
  input  wire logic cnt_ret,
  output logic      clr_fault_cmd,
  output logic      clr_counter_cmd
);
  // Bits stay up until the block returns them, so a slow answer is never lost
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clr_fault_cmd   <= 1'b0;
      clr_counter_cmd <= 1'b0;
    end else begin
      // The return pulse wins over a new request in the same cycle
      clr_fault_cmd   <= flt_ret ? 1'b0 : (flt_req | clr_fault_cmd);
      clr_counter_cmd <= cnt_ret ? 1'b0 : (cnt_req | clr_counter_cmd);
    end
  end
endmodule

// File: verif/motor_driver_status_regs_test.sv
// Self-checking bench for the motor driver status register bank.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/1ns
module motor_driver_status_regs_test;
  logic                  clk, nrst, vcc_ok, en_out, rpl, rd_en, rd_valid;
  logic                  cfg_en, flt_cmd, cnt_cmd, flt_ret, cnt_ret, pin_n;
  logic                  flt_req, cnt_req;
  mdsr_pkg::mdsr_events_s ev;
  mdsr_pkg::mdsr_cfg_wr_s cfg_out;
  logic [15:0]           thr;
  logic [13:0]           mv;
  logic [8:0]            iraw;
  logic [7:0]            speed, rd_addr, rd_data, cfg_addr, cfg_data;
  logic [5:0]            duty;
  int                    n_errors, check_count;

  mdsr_status_regs uut (.CLK(clk), .NRST(nrst), .FAULT_EVENTS(ev), .VCC_OK(vcc_ok),
    .CLR_FAULT_CMD(flt_cmd), .CLR_COUNTER_CMD(cnt_cmd), .EN_OUT(en_out),
    .RIPPLE_PULSE(rpl), .RIPPLE_THRESHOLD(thr), .SPEED_IN(speed), .MOTOR_MV(mv),
    .MOTOR_I_RAW(iraw), .DUTY_IN(duty), .RD_EN(rd_en), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .CFG_WR_EN(cfg_en), .CFG_WR_ADDR(cfg_addr),
    .CFG_WR_DATA(cfg_data), .CFG_WR_OUT(cfg_out), .CLR_FAULT_RET(flt_ret),
    .CLR_COUNTER_RET(cnt_ret), .FAULT_PIN_N(pin_n));

  mdsr_host_model host (.clk(clk), .nrst(nrst), .flt_req(flt_req), .cnt_req(cnt_req),
    .flt_ret(flt_ret), .cnt_ret(cnt_ret), .clr_fault_cmd(flt_cmd),
    .clr_counter_cmd(cnt_cmd));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One register read; a missing answer ends the run
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
    int i;
    @(posedge clk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (rd_valid !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
    chk(what, rd_data, e);
  endtask

  // Issue a clear command through the host model and wait for its return
  task automatic clr(input logic cnt);
    int i;
    @(posedge clk);
    flt_req <= !cnt;
    cnt_req <= cnt;
    @(posedge clk);
    flt_req <= 1'b0;
    cnt_req <= 1'b0;
    for (i = 0; i < 8 && (cnt ? cnt_ret : flt_ret) !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if ((cnt ? cnt_ret : flt_ret) !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
    tick(3);
  endtask

  // Single-cycle ripples, spaced so each one counts once
  task automatic rip(input int n);
    repeat (n) begin
      @(posedge clk);
      rpl <= 1'b1;
      @(posedge clk);
      rpl <= 1'b0;
    end
    tick(4);
  endtask

  // Config write through the lock gate; only listed offsets are touched
  task automatic cfgw(input logic [7:0] a, input logic en, input logic [7:0] m);
    @(posedge clk);
    en_out   <= en;
    cfg_en   <= 1'b1;
    cfg_addr <= a;
    cfg_data <= 8'h5a;
    @(posedge clk);
    cfg_en <= 1'b0;
    #1;
    chk("cfg we", {7'h00, cfg_out.we}, 8'h01);
    chk("cfg mask", cfg_out.mask, m);
    chk("cfg addr", cfg_out.addr, a);
    chk("cfg data", cfg_out.data, 8'h5a);
  endtask

  // Offsets 00h to 07h, unmapped 07h included, read zero out of reset
  task automatic t_reset();
    logic [7:0] a;
    #1;
    chk("pin idle", {7'h00, pin_n}, 8'h01);
    for (a = 8'h00; a < 8'h08; a++) begin
      rdchk(a, 8'h00, "reset value");
    end
    $display("test reset done");
  endtask

  // Each fault sets its flag and the summary, sticks over reads, then clears
  task automatic t_faults();
    int         i;
    logic [7:0] e;
    for (i = 0; i < 4; i++) begin
      e = 8'h80 | (8'h20 >> i) | ((i > 0) ? 8'h02 : 8'h00);
      @(posedge clk);
      ev <= 4'b1000 >> i;
      @(posedge clk);
      ev <= '0;
      #1;
      chk("pin fault", {7'h00, pin_n}, 8'h00);
      rdchk(mdsr_pkg::OFS_FAULT_STATUS, e, "fault flags");
      rdchk(mdsr_pkg::OFS_FAULT_STATUS, e, "fault reread");
      clr(1'b0);
      rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h02, "fault cleared");
      chk("pin released", {7'h00, pin_n}, 8'h01);
    end
    // Supply dip drops the power-on flag until the next clear
    @(posedge clk);
    vcc_ok <= 1'b0;
    tick(2);
    rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h00, "supply low");
    @(posedge clk);
    vcc_ok <= 1'b1;
    tick(2);
    rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h00, "supply back");
    clr(1'b0);
    rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h02, "power on set");
    $display("test faults done");
  endtask

  // Count up to the threshold, one past it, read both bytes, then clear
  task automatic t_ripple();
    rip(258);
    rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h02, "at threshold");
    rip(1);
    rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h03, "past threshold");
    rdchk(mdsr_pkg::OFS_RIPPLE_LOW, 8'h03, "count low");
    rdchk(mdsr_pkg::OFS_RIPPLE_HIGH, 8'h01, "count high");
    rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h03, "done reread");
    clr(1'b1);
    rdchk(mdsr_pkg::OFS_FAULT_STATUS, 8'h02, "done cleared");
    rdchk(mdsr_pkg::OFS_RIPPLE_LOW, 8'h00, "low zeroed");
    rdchk(mdsr_pkg::OFS_RIPPLE_HIGH, 8'h00, "high zeroed");
    $display("test ripple done");
  endtask

  // Engine values and voltage scaling up to saturation
  task automatic t_values();
    int mvs[4] = '{0, 5500, 11000, 16383};
    int i;
    int e;
    @(posedge clk);
    speed <= 8'ha5;
    duty  <= 6'h3f;
    iraw  <= 9'h100;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      mv <= mvs[i][13:0];
      tick(3);
      e = mvs[i] * 176 / 11000;
      rdchk(mdsr_pkg::OFS_MOTOR_VOLTAGE, (e > 255) ? 8'hff : e[7:0], "voltage");
    end
    rdchk(mdsr_pkg::OFS_SPEED_ESTIMATE, 8'ha5, "speed");
    rdchk(mdsr_pkg::OFS_MOTOR_CURRENT, 8'hc0, "current");
    rdchk(mdsr_pkg::OFS_INTERNAL_DUTY, 8'h3f, "duty");
    $display("test values done");
  endtask

  // Locked bits refused while the outputs are enabled
  task automatic t_lock();
    cfgw(mdsr_pkg::OFS_CONFIG0, 1'b1, 8'he6);
    cfgw(mdsr_pkg::OFS_CONFIG3, 1'b1, 8'h00);
    cfgw(mdsr_pkg::OFS_CONFIG4, 1'b1, 8'hf3);
    cfgw(mdsr_pkg::OFS_REG_CTRL0, 1'b1, 8'he3);
    cfgw(mdsr_pkg::OFS_CONFIG3, 1'b0, 8'hff);
    cfgw(8'h0a, 1'b1, 8'hff);
    $display("test lock done");
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    n_errors    = 0;
    check_count = 0;
    nrst        = 1'b0;
    ev          = '0;
    vcc_ok      = 1'b1;
    en_out      = 1'b0;
    rpl         = 1'b0;
    thr         = 16'h0102;
    speed       = 8'h00;
    mv          = 14'h0000;
    iraw        = 9'h000;
    duty        = 6'h00;
    rd_en       = 1'b0;
    rd_addr     = 8'h00;
    cfg_en      = 1'b0;
    cfg_addr    = 8'h00;
    cfg_data    = 8'h00;
    flt_req     = 1'b0;
    cnt_req     = 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_faults();
    t_ripple();
    t_values();
    t_lock();
    wrap_up();
  end
endmodule
